// [exec_pkg.sv]
package exec_pkg;

	// ------------------------------------------------------------
	// Widths and sizes
	// ------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam int PC_W = 10;
	localparam int PAGE_AW = 4;
	localparam int PAGE_DEPTH = 16;

	// ------------------------------------------------------------
	// Reset values and cycle counts
	// ------------------------------------------------------------
	localparam logic [DATA_W-1:0] WORK_RESET = 8'h00;
	localparam logic [PC_W-1:0] PC_RESET = 10'h000;
	localparam logic [PC_W-1:0] PC_STEP = 10'h001;
	localparam logic [DATA_W-1:0] PAGE_RESET = 8'h00;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
	localparam int SHORT_CYCLES = 1;
	localparam int LONG_CYCLES = 2;

	// Instructions this unit executes
	typedef enum logic [2:0] {
		no_op,
		or_immediate_op,
		load_immediate_op,
		periph_page_read_op,
		periph_page_write_op,
		long_call_op,
		long_branch_op
	} op_type;

	// Issue phase: run takes a new instruction, wait is the
	// second cycle of a long instruction
	typedef enum logic {
		phase_run,
		phase_wait
	} phase_type;

endpackage

// [page_bus_if.sv]
`timescale 1ns/1ps
interface page_bus_if;
	import exec_pkg::*;

	logic wr_en;
	logic [PAGE_AW-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic [PAGE_AW-1:0] rd_addr;
	logic [DATA_W-1:0] rd_data;

	modport ctrl (
		output wr_en,
		output wr_addr,
		output wr_data,
		output rd_addr,
		input rd_data
	);

	modport mem (
		input wr_en,
		input wr_addr,
		input wr_data,
		input rd_addr,
		output rd_data
	);

endinterface

// [periph_page_mem.sv]
`timescale 1ns/1ps
module periph_page_mem (
	input wire logic clk,
	input wire logic rst,
	page_bus_if.mem bus
);
	import exec_pkg::*;

	logic [DATA_W-1:0] entry_r [PAGE_DEPTH];
	logic [DATA_W-1:0] rd_data_r;

	// ------------------------------------------------------------
	// Storage, one register per page entry
	// ------------------------------------------------------------
	for (genvar i = 0; i < PAGE_DEPTH; i++) begin : g_entry
		// Entry is loaded when the write index matches
		always_ff @(posedge clk) begin
			if (rst) begin
				entry_r[i] <= PAGE_RESET;
			end else if (bus.wr_en && bus.wr_addr == PAGE_AW'(i)) begin
				entry_r[i] <= bus.wr_data;
			end
		end
	end

	// ------------------------------------------------------------
	// Registered read port
	// ------------------------------------------------------------
	// A write to the same index in the same cycle is forwarded
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_data_r <= PAGE_RESET;
		end else if (bus.wr_en && bus.wr_addr == bus.rd_addr) begin
			rd_data_r <= bus.wr_data;
		end else begin
			rd_data_r <= entry_r[bus.rd_addr];
		end
	end

	assign bus.rd_data = rd_data_r;

endmodule

// [instr_exec.sv]
`timescale 1ns/1ps
module instr_exec (
	input wire logic clk,
	input wire logic rst,
	input wire logic instr_valid,
	input wire exec_pkg::op_type instr_op,
	input wire logic [exec_pkg::PC_W-1:0] instr_arg,
	output logic instr_ready,
	output logic [exec_pkg::DATA_W-1:0] working_register,
	output logic zero_flag,
	output logic [exec_pkg::PC_W-1:0] pc,
	output logic stack_push,
	output logic [exec_pkg::PC_W-1:0] stack_push_addr,
	output logic retired
);
	import exec_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		phase_type phase;
		logic ready;
		logic stage_valid;
		op_type stage_op;
		logic [PC_W-1:0] stage_arg;
		logic [DATA_W-1:0] work;
		logic zero;
		logic [PC_W-1:0] pc;
		logic push;
		logic [PC_W-1:0] push_addr;
		logic retired;
	} state_type;

	state_type state_r;
	state_type state_nxt;
	logic take;
	logic [DATA_W-1:0] imm;
	logic [DATA_W-1:0] or_result;
	logic [PC_W-1:0] next_pc;

	page_bus_if page_bus ();

	periph_page_mem u_page (
		.clk(clk),
		.rst(rst),
		.bus(page_bus)
	);

	// ------------------------------------------------------------
	// Issue and page access
	// ------------------------------------------------------------
	// Instruction is taken while ready; the read index goes to the
	// page at the same edge so the data meets the execute stage
	assign take = instr_valid && state_r.ready;
	assign page_bus.rd_addr = instr_arg[PAGE_AW-1:0];

	// Page write happens from the execute stage
	assign page_bus.wr_en = state_r.stage_valid &&
		state_r.stage_op == periph_page_write_op;
	assign page_bus.wr_addr = state_r.stage_arg[PAGE_AW-1:0];
	assign page_bus.wr_data = state_r.work;

	// Operand helpers
	assign imm = state_r.stage_arg[DATA_W-1:0];
	assign or_result = state_r.work | imm;
	assign next_pc = state_r.pc + PC_STEP;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		state_nxt.push = 1'b0;
		state_nxt.retired = 1'b0;

		// Issue phase, long instructions hold off one cycle
		case (state_r.phase)
			phase_run: begin
				if (take && (instr_op == long_call_op ||
					instr_op == long_branch_op)) begin
					state_nxt.phase = phase_wait;
					state_nxt.ready = 1'b0;
				end
			end
			phase_wait: begin
				state_nxt.phase = phase_run;
				state_nxt.ready = 1'b1;
			end
			default: begin
				state_nxt.phase = phase_run;
				state_nxt.ready = 1'b1;
			end
		endcase

		// Decode stage register
		state_nxt.stage_valid = take;
		if (take) begin
			state_nxt.stage_op = instr_op;
			state_nxt.stage_arg = instr_arg;
		end

		// Execute stage
		if (state_r.stage_valid) begin
			state_nxt.retired = 1'b1;
			state_nxt.pc = next_pc;
			case (state_r.stage_op)
				or_immediate_op: begin
					state_nxt.work = or_result;
					state_nxt.zero = (or_result == ZERO_BYTE);
				end
				load_immediate_op: begin
					state_nxt.work = imm;
				end
				periph_page_read_op: begin
					state_nxt.work = page_bus.rd_data;
				end
				periph_page_write_op: begin
					state_nxt.work = state_r.work;
				end
				long_call_op: begin
					state_nxt.push = 1'b1;
					state_nxt.push_addr = next_pc;
					state_nxt.pc = state_r.stage_arg;
				end
				long_branch_op: begin
					state_nxt.pc = state_r.stage_arg;
				end
				default: begin
					state_nxt.work = state_r.work;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r.phase <= phase_run;
			state_r.ready <= 1'b1;
			state_r.stage_valid <= 1'b0;
			state_r.stage_op <= no_op;
			state_r.stage_arg <= PC_RESET;
			state_r.work <= WORK_RESET;
			state_r.zero <= 1'b0;
			state_r.pc <= PC_RESET;
			state_r.push <= 1'b0;
			state_r.push_addr <= PC_RESET;
			state_r.retired <= 1'b0;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Outputs straight from the state register
	assign instr_ready = state_r.ready;
	assign working_register = state_r.work;
	assign zero_flag = state_r.zero;
	assign pc = state_r.pc;
	assign stack_push = state_r.push;
	assign stack_push_addr = state_r.push_addr;
	assign retired = state_r.retired;

endmodule

// [instr_exec_assertions.sv]
`timescale 1ns/1ps
module instr_exec_assertions
	import exec_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic instr_valid,
	input wire op_type instr_op,
	input wire logic [PC_W-1:0] instr_arg,
	input wire logic instr_ready,
	input wire logic [DATA_W-1:0] working_register,
	input wire logic zero_flag,
	input wire logic [PC_W-1:0] pc,
	input wire logic stack_push,
	input wire logic [PC_W-1:0] stack_push_addr,
	input wire logic retired
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic take;
	// Instruction accepted at this edge
	assign take = instr_valid && instr_ready;
	// Long op: one stalled cycle, then retire
	sequence long_done;
		!instr_ready ##1 (instr_ready && retired);
	endsequence
	a_or_result: assert property (take && instr_op == or_immediate_op |-> ##2
		working_register == ($past(working_register) | $past(instr_arg[7:0], 2))
		&& zero_flag == (working_register == ZERO_BYTE)) else $error("or bad");
	a_load_value: assert property (take && instr_op == load_immediate_op
		|-> ##2 working_register == $past(instr_arg[7:0], 2) && $stable(zero_flag))
		else $error("load bad");
	a_short_step: assert property (take && instr_op inside {or_immediate_op,
		load_immediate_op, periph_page_read_op, periph_page_write_op} |-> ##2
		retired && !stack_push && pc == $past(pc) + PC_STEP) else $error("step bad");
	a_page_flags: assert property (take && instr_op inside {periph_page_read_op,
		periph_page_write_op} |-> ##2 $stable(zero_flag)) else $error("flag bad");
	a_call_push: assert property (take && instr_op == long_call_op |-> ##2
		stack_push && stack_push_addr == $past(pc) + PC_STEP
		&& pc == $past(instr_arg, 2)) else $error("call bad");
	a_branch_target: assert property (take && instr_op == long_branch_op |-> ##2
		!stack_push && pc == $past(instr_arg, 2) && $stable(zero_flag))
		else $error("branch bad");
	a_long_stall: assert property (take && instr_op inside {long_call_op,
		long_branch_op} |=> long_done) else $error("stall bad");
endmodule

// [mcu_instr_exec_subset_test.sv]
`timescale 1ns/1ps
module mcu_instr_exec_subset_test;
	import exec_pkg::*;
	logic clk, rst, instr_valid, instr_ready, zero_flag, stack_push, retired;
	op_type instr_op;
	logic [PC_W-1:0] instr_arg, pc, stack_push_addr, exp_pc;
	logic [DATA_W-1:0] working_register;
	int error_cnt, comparisons;
	instr_exec DUT (
		.clk(clk),
		.rst(rst),
		.instr_valid(instr_valid),
		.instr_op(instr_op),
		.instr_arg(instr_arg),
		.instr_ready(instr_ready),
		.working_register(working_register),
		.zero_flag(zero_flag),
		.pc(pc),
		.stack_push(stack_push),
		.stack_push_addr(stack_push_addr),
		.retired(retired)
	);
	// Clock, 5 ns period
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	task chk(logic [31:0] got, logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Issue one op, wait its fixed latency, check pc and pulses
	task op(op_type o, logic [PC_W-1:0] a);
		logic lng;
		logic [PC_W-1:0] nx;
		lng = (o == long_call_op || o == long_branch_op);
		nx = lng ? a : exp_pc + PC_STEP;
		@(posedge clk);
		instr_valid <= 1'b1;
		instr_op <= o;
		instr_arg <= a;
		@(posedge clk);
		instr_valid <= 1'b0;
		#1;
		if (lng) chk(instr_ready, 1'b0);
		@(posedge clk);
		#1;
		chk({retired, stack_push, pc}, {1'b1, o == long_call_op, nx});
		if (o == long_call_op) chk(stack_push_addr, exp_pc + PC_STEP);
		exp_pc = nx;
	endtask
	task t_imm;
		op(load_immediate_op, 10'h0AA);
		chk({working_register, zero_flag}, {8'hAA, 1'b0});
		op(or_immediate_op, 10'h050);
		chk({working_register, zero_flag}, {8'hFA, 1'b0});
		op(load_immediate_op, 10'h300);
		chk({working_register, zero_flag}, {8'h00, 1'b0});
		op(or_immediate_op, 10'h300);
		chk({working_register, zero_flag}, {8'h00, 1'b1});
	endtask
	// Lowest and highest page index
	task t_page;
		for (int i = 0; i < 16; i += 15) begin
			op(load_immediate_op, 10'h020 + 10'(i));
			op(periph_page_write_op, 10'(i));
			chk(zero_flag, 1'b1);
			op(load_immediate_op, 10'h000);
			op(periph_page_read_op, 10'(i));
			chk({working_register, zero_flag}, {8'h20 + 8'(i), 1'b1});
		end
	endtask
	task t_long;
		op(long_call_op, 10'h3FF);
		op(long_branch_op, 10'h000);
		op(long_call_op, 10'h123);
		op(no_op, 10'h000);
		chk({working_register, zero_flag}, {8'h2F, 1'b1});
		op(or_immediate_op, 10'h040);
		chk({working_register, zero_flag}, {8'h6F, 1'b0});
	endtask
	// Write, read and OR on back-to-back edges, same page index
	task t_fwd;
		op(load_immediate_op, 10'h05A);
		@(posedge clk);
		instr_valid <= 1'b1;
		instr_op <= periph_page_write_op;
		instr_arg <= 10'h007;
		@(posedge clk);
		instr_op <= periph_page_read_op;
		@(posedge clk);
		instr_op <= or_immediate_op;
		instr_arg <= 10'h0A5;
		@(posedge clk);
		instr_valid <= 1'b0;
		@(posedge clk);
		#1;
		chk({working_register, zero_flag}, {8'hFF, 1'b0});
		chk(pc, exp_pc + 10'h003);
		exp_pc = exp_pc + 10'h003;
	endtask
	task end_of_test;
		if (error_cnt == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Reset, then scenarios
	initial begin
		rst = 1'b1;
		instr_valid = 1'b0;
		instr_op = no_op;
		instr_arg = 10'h000;
		exp_pc = 10'h000;
		error_cnt = 0;
		comparisons = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk({working_register, zero_flag, pc, instr_ready}, 20'h0_0001);
		t_imm();
		t_page();
		t_long();
		t_fwd();
		end_of_test();
	end
endmodule
bind instr_exec instr_exec_assertions chk_i (
	.clk(clk),
	.rst(rst),
	.instr_valid(instr_valid),
	.instr_op(instr_op),
	.instr_arg(instr_arg),
	.instr_ready(instr_ready),
	.working_register(working_register),
	.zero_flag(zero_flag),
	.pc(pc),
	.stack_push(stack_push),
	.stack_push_addr(stack_push_addr),
	.retired(retired)
);
